/* hw/iox_pkg.sv */
// Purpose: Shared constants, types and states of the I/O expander.
// Assumes: Eight pins per port, two ports, eight byte registers.
// Notes: Every register offset, register reset value and pair code lives here.
package iox_pkg;

  // ----------------------------------------------------------------
  // Widths and bus address
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int STRAP_W = 3;
  localparam int NUM_PORTS = 2;
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic RW_READ = 1'b1;

  // ----------------------------------------------------------------
  // Register pointer encoding
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_IN0 = 3'h0;
  localparam logic [2:0] REG_IN1 = 3'h1;
  localparam logic [2:0] REG_LATCH0 = 3'h2;
  localparam logic [2:0] REG_LATCH1 = 3'h3;
  localparam logic [2:0] REG_INV0 = 3'h4;
  localparam logic [2:0] REG_INV1 = 3'h5;
  localparam logic [2:0] REG_DIR0 = 3'h6;
  localparam logic [2:0] REG_DIR1 = 3'h7;
  localparam logic [1:0] PAIR_IN = 2'h0;
  localparam logic [1:0] PAIR_LATCH = 2'h1;
  localparam logic [1:0] PAIR_INV = 2'h2;
  localparam logic [1:0] PAIR_DIR = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] INV_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [2:0] PTR_RST = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] latch;
    logic [7:0] invert;
  } iox_port_cfg_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } iox_bus_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_MACK, ST_IGNORE
  } iox_state_t;

endpackage : iox_pkg

/* hw/iox_sync.sv */
// Purpose: Two flip-flop synchroniser for signals from outside the clock domain.
// Assumes: Bits are independent levels; no word coherence is needed.
// Notes: Carries no reset; hold reset long enough to flush it.
`timescale 1ns/1ns
module iox_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk,
  // Asynchronous levels and their synchronised copies
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end

endmodule : iox_sync

/* hw/iox_port.sv */
// Purpose: One eight-pin port: pin drivers, reported level and change detect.
// Assumes: pinSync is already synchronised to clk.
// Notes: The snapshot holds the uninverted pins sampled by the last read of this port.
`timescale 1ns/1ns
module iox_port import iox_pkg::*; #(
  parameter int W = PORT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pin side
  input wire logic [W-1:0] pinSync,
  output logic [W-1:0] pinOut,
  output logic [W-1:0] pinOe,
  // Register side
  input wire iox_port_cfg_t cfg,
  input wire logic snapLoad,
  output logic [W-1:0] level,
  output logic changed
);

  logic [W-1:0] snap_q;

  if (W != PORT_W) begin : gWidthCheck
    $error("iox_port width must equal the register width");
  end

  // Drivers follow the latch only where the direction bit selects output.
  always_ff @(posedge clk) begin
    if (srst) begin
      pinOut <= LATCH_RST;
      pinOe <= ~DIR_RST;
    end else begin
      pinOut <= cfg.latch;
      pinOe <= ~cfg.dir;
    end
  end

  // Reset takes the present pins so that no change is flagged at start.
  always_ff @(posedge clk) begin
    if (srst || snapLoad) begin
      snap_q <= pinSync;
    end
  end

  assign level = pinSync ^ cfg.invert;
  assign changed = |((pinSync ^ snap_q) & cfg.dir);

endmodule : iox_port

/* hw/iox_expander.sv */
// Purpose: Two-wire bus slave sixteen-bit I/O expander with two eight-pin ports.
// Assumes: core_clk is far faster than the bus clock; all pins are asynchronous.
// Notes: Bus lines and pins are sampled on core_clk; bus lines are edge-detected, pins compared with a snapshot.
//
// Functional notes
// - Answer address 0100 plus three strap bits.
// - Direction bit one reads, zero writes.
// - First written byte sets three-bit register pointer.
// - Stored pointer persists for later reads.
// - Pointer selects input, latch, invert, direction pairs.
// - Input register shows pin level, any direction.
// - Writes to input registers are discarded.
// - Latch drives only pins set as outputs.
// - Latch read returns stored latch, not pins.
// - Invert bit one reports the input inverted.
// - Direction one is input, zero drives output.
// - Each written byte toggles to pair partner.
// - Unlimited data bytes per write transfer.
// - Pointer follows register being read at restart.
// - Each further read byte alternates within pair.
// - Pin data captured at acknowledge rising edge.
// - Stop anywhere; last acknowledged data stays valid.
// - Input pin change asserts active-low interrupt.
// - Interrupt clears on port read or level return.
// - General call address is never acknowledged.
`timescale 1ns/1ns
module iox_expander import iox_pkg::*; #(
  parameter int W = PORT_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Two-wire bus
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Address straps
  input wire logic [STRAP_W-1:0] addrStrapPins,
  // First port pins
  input wire logic [W-1:0] firstPortPinsIn,
  output logic [W-1:0] firstPortPinsOut,
  output logic [W-1:0] firstPortPinsOe,
  // Second port pins
  input wire logic [W-1:0] secondPortPinsIn,
  output logic [W-1:0] secondPortPinsOut,
  output logic [W-1:0] secondPortPinsOe,
  // Open-drain interrupt, pulls low while intOe is high
  output logic intOut,
  output logic intOe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  iox_bus_t busSync;
  logic [STRAP_W-1:0] strapSync;
  logic [2*W-1:0] pinSyncAll;
  logic [W-1:0] pinSync [NUM_PORTS];
  logic [W-1:0] pinOutArr [NUM_PORTS];
  logic [W-1:0] pinOeArr [NUM_PORTS];
  logic [W-1:0] level [NUM_PORTS];
  logic [NUM_PORTS-1:0] changed;
  logic [NUM_PORTS-1:0] snapLoad;
  iox_port_cfg_t cfg_q [NUM_PORTS];
  logic [7:0] regView [8];

  iox_state_t state_q;
  logic sclPrev_q;
  logic sdaPrev_q;
  logic [2:0] bitCnt_q;
  logic [6:0] rx_q;
  logic [7:0] rxNext;
  logic rw_q;
  logic ackSeen_q;
  logic [2:0] ptr_q;
  logic [7:0] wData_q;
  logic [7:0] txByte_q;
  logic sdaOe_q;
  logic intOe_q;

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic inAck;
  logic inRecv;
  logic byteDone;
  logic addrHit;
  logic ackRise;
  logic readLoad;
  logic masterAckRise;
  logic wrCommit;
  logic [2:0] loadSel;

  if (W != PORT_W) begin : gWidthCheck
    $error("iox_expander port width must equal the register width");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  iox_sync #(.W(2)) uBusSync (
    .clk(core_clk),
    .d({scl, sdaIn}),
    .q(busSync)
  );

  iox_sync #(.W(STRAP_W)) uStrapSync (
    .clk(core_clk),
    .d(addrStrapPins),
    .q(strapSync)
  );

  iox_sync #(.W(2 * W)) uPinSync (
    .clk(core_clk),
    .d({secondPortPinsIn, firstPortPinsIn}),
    .q(pinSyncAll)
  );

  assign pinSync[0] = pinSyncAll[W-1:0];
  assign pinSync[1] = pinSyncAll[2*W-1:W];

  // ----------------------------------------------------------------
  // Bus event detection
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= busSync.scl;
      sdaPrev_q <= busSync.sda;
    end
  end

  assign sclRise = busSync.scl && !sclPrev_q;
  assign sclFall = !busSync.scl && sclPrev_q;
  assign startCond = busSync.scl && sclPrev_q && sdaPrev_q && !busSync.sda;
  assign stopCond = busSync.scl && sclPrev_q && !sdaPrev_q && busSync.sda;

  assign inAck = (state_q == ST_ADDR_ACK) || (state_q == ST_CMD_ACK)
    || (state_q == ST_WDATA_ACK);
  assign inRecv = (state_q == ST_ADDR) || (state_q == ST_CMD)
    || (state_q == ST_WDATA);
  assign rxNext = {rx_q, busSync.sda};
  assign byteDone = sclRise && (bitCnt_q == LAST_BIT);
  // The general call address carries zeros in the fixed field and never hits.
  assign addrHit = (rxNext[7:1] == {ADDR_FIXED, strapSync});
  assign ackRise = inAck && sclRise;
  assign readLoad = (state_q == ST_ADDR_ACK) && sclRise && (rw_q == RW_READ);
  assign masterAckRise = (state_q == ST_MACK) && sclRise && !busSync.sda;
  assign wrCommit = (state_q == ST_WDATA_ACK) && sclRise;
  assign loadSel = readLoad ? ptr_q : {ptr_q[2:1], ~ptr_q[0]};

  // ----------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else if (startCond) begin
      state_q <= ST_ADDR;
    end else if (stopCond) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_IGNORE: begin
          state_q <= state_q;
        end
        ST_ADDR: begin
          if (byteDone) begin
            state_q <= addrHit ? ST_ADDR_ACK : ST_IGNORE;
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall && ackSeen_q) begin
            state_q <= (rw_q == RW_READ) ? ST_RDATA : ST_CMD;
          end
        end
        ST_CMD: begin
          if (byteDone) begin
            state_q <= ST_CMD_ACK;
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          if (sclFall && ackSeen_q) begin
            state_q <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byteDone) begin
            state_q <= ST_WDATA_ACK;
          end
        end
        ST_RDATA: begin
          if (byteDone) begin
            state_q <= ST_MACK;
          end
        end
        ST_MACK: begin
          if (sclRise) begin
            state_q <= busSync.sda ? ST_IGNORE : ST_RDATA;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bit counter, receive shifter and direction bit
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst || startCond) begin
      bitCnt_q <= 3'h0;
    end else if (sclRise && (inRecv || state_q == ST_RDATA)) begin
      bitCnt_q <= bitCnt_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_q <= 7'h00;
      rw_q <= 1'b0;
    end else if (sclRise && inRecv) begin
      rx_q <= rxNext[6:0];
      if (state_q == ST_ADDR && bitCnt_q == LAST_BIT) begin
        rw_q <= rxNext[0];
      end
    end
  end

  // The acknowledge flag marks that the ninth clock has risen.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ackSeen_q <= 1'b0;
    end else begin
      ackSeen_q <= inAck && (ackSeen_q || sclRise);
    end
  end

  // ----------------------------------------------------------------
  // Register pointer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ptr_q <= PTR_RST;
    end else if (state_q == ST_CMD && byteDone) begin
      ptr_q <= rxNext[2:0];
    end else if (wrCommit || masterAckRise) begin
      // Reads move the stored pointer too, so a restart resumes here.
      ptr_q <= {ptr_q[2:1], ~ptr_q[0]};
    end
  end

  // ----------------------------------------------------------------
  // Write data and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wData_q <= 8'h00;
    end else if (state_q == ST_WDATA && byteDone) begin
      wData_q <= rxNext;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        cfg_q[i] <= '{dir: DIR_RST, latch: LATCH_RST, invert: INV_RST};
      end
    end else if (wrCommit) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (ptr_q[0] == i[0]) begin
          unique case (ptr_q[2:1])
            PAIR_IN: cfg_q[i] <= cfg_q[i];
            PAIR_LATCH: cfg_q[i].latch <= wData_q;
            PAIR_INV: cfg_q[i].invert <= wData_q;
            PAIR_DIR: cfg_q[i].dir <= wData_q;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read view and transmit byte
  // ----------------------------------------------------------------
  always_comb begin
    regView[REG_IN0] = level[0];
    regView[REG_IN1] = level[1];
    regView[REG_LATCH0] = cfg_q[0].latch;
    regView[REG_LATCH1] = cfg_q[1].latch;
    regView[REG_INV0] = cfg_q[0].invert;
    regView[REG_INV1] = cfg_q[1].invert;
    regView[REG_DIR0] = cfg_q[0].dir;
    regView[REG_DIR1] = cfg_q[1].dir;
  end

  // Pin data is caught on the rising clock of the read address acknowledge and of each master acknowledge.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      txByte_q <= 8'h00;
    end else if (readLoad || masterAckRise) begin
      txByte_q <= regView[loadSel];
    end
  end

  always_comb begin
    snapLoad = '0;
    if ((readLoad || masterAckRise) && loadSel[2:1] == PAIR_IN) begin
      snapLoad[loadSel[0]] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Data line driver
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst || startCond || stopCond) begin
      sdaOe_q <= 1'b0;
    end else if (sclFall) begin
      unique case (state_q)
        ST_ADDR_ACK: begin
          if (!ackSeen_q) begin
            sdaOe_q <= 1'b1;
          end else begin
            sdaOe_q <= (rw_q == RW_READ) && !txByte_q[LAST_BIT];
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          sdaOe_q <= !ackSeen_q;
        end
        ST_RDATA: begin
          sdaOe_q <= !txByte_q[LAST_BIT - bitCnt_q];
        end
        default: begin
          sdaOe_q <= 1'b0;
        end
      endcase
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_q;

  // ----------------------------------------------------------------
  // Ports and interrupt
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_PORTS; g++) begin : gPort
    iox_port #(.W(W)) uPort (
      .clk(core_clk),
      .srst(srst),
      .pinSync(pinSync[g]),
      .pinOut(pinOutArr[g]),
      .pinOe(pinOeArr[g]),
      .cfg(cfg_q[g]),
      .snapLoad(snapLoad[g]),
      .level(level[g]),
      .changed(changed[g])
    );
  end

  assign firstPortPinsOut = pinOutArr[0];
  assign firstPortPinsOe = pinOeArr[0];
  assign secondPortPinsOut = pinOutArr[1];
  assign secondPortPinsOe = pinOeArr[1];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      intOe_q <= 1'b0;
    end else begin
      intOe_q <= |changed;
    end
  end

  assign intOut = 1'b0;
  assign intOe = intOe_q;

endmodule : iox_expander

/* tb/iox_expander_chk.sv */
// Purpose: Port-level assertions for the two-wire I/O expander.
// Assumes: Every bus clock phase lasts at least four core clocks.
// Notes: Bound to the expander and sees only its ports.
`timescale 1ns/1ns
module iox_expander_chk import iox_pkg::*; #(
  parameter int W = PORT_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Bus
  input wire logic scl,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Pins and interrupt
  input wire logic [W-1:0] firstPortPinsOut,
  input wire logic [W-1:0] firstPortPinsOe,
  input wire logic [W-1:0] secondPortPinsOut,
  input wire logic [W-1:0] secondPortPinsOe,
  input wire logic intOut,
  input wire logic intOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  property p_rst_vals;
    $fell(srst) |-> !sdaOe && !intOe && firstPortPinsOe == '0 && secondPortPinsOe == '0
      && firstPortPinsOut == LATCH_RST && secondPortPinsOut == LATCH_RST;
  endproperty
  property p_oe1;
    $changed(firstPortPinsOe) |-> sdaOe;
  endproperty
  property p_out1;
    $changed(firstPortPinsOut) |-> sdaOe;
  endproperty
  property p_oe2;
    $changed(secondPortPinsOe) |-> sdaOe;
  endproperty
  property p_out2;
    $changed(secondPortPinsOut) |-> sdaOe;
  endproperty
  property p_sda_phase;
    $changed(sdaOe) |-> !$past(scl, 2);
  endproperty
  property p_sda_hold;
    $rose(sdaOe) |=> sdaOe [*4];
  endproperty
  property p_int_inputs;
    $rose(intOe) |-> !((&firstPortPinsOe) && (&secondPortPinsOe));
  endproperty
  property p_open_drain;
    !sdaOut && !intOut;
  endproperty

  a_rst_vals: assert property (p_rst_vals) else $error("reset outputs wrong");
  a_oe1: assert property (p_oe1) else $error("port 0 drive changed off ack");
  a_out1: assert property (p_out1) else $error("port 0 latch changed off ack");
  a_oe2: assert property (p_oe2) else $error("port 1 drive changed off ack");
  a_out2: assert property (p_out2) else $error("port 1 latch changed off ack");
  a_sda_phase: assert property (p_sda_phase) else $error("data moved in high");
  a_sda_hold: assert property (p_sda_hold) else $error("data low too short");
  a_int_inputs: assert property (p_int_inputs) else $error("int with no input");
  a_open_drain: assert property (p_open_drain) else $error("line driven high");

  c_ack: cover property ($rose(sdaOe));
  c_int_set: cover property ($rose(intOe));
  c_int_clr: cover property ($fell(intOe));
  c_pin: cover property ($changed(firstPortPinsOe));
endmodule : iox_expander_chk

bind iox_expander iox_expander_chk #(.W(W)) u_chk (
  .core_clk(core_clk), .srst(srst), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .firstPortPinsOut(firstPortPinsOut), .firstPortPinsOe(firstPortPinsOe),
  .secondPortPinsOut(secondPortPinsOut), .secondPortPinsOe(secondPortPinsOe),
  .intOut(intOut), .intOe(intOe)
);

/* tb/iox_bus_master.sv */
// Purpose: Behavioural two-wire bus master facing the expander.
// Assumes: An 80 ns bus period, four core clocks per phase.
// Notes: SDA is open drain; sdaLow pulls it down, the pull-up lifts it.
`timescale 1ns/1ns
module iox_bus_master (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sdaWire,
  output logic scl = 1'b1,
  output logic sdaLow = 1'b0
);
  // Data moves a clock after SCL falls, so no false start or stop is seen.
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk);
    sdaLow <= ~b;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    r = sdaWire;
    scl <= 1'b0;
  endtask : bit_io

  task automatic start();
    @(posedge clk);
    sdaLow <= 1'b0;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sdaLow <= 1'b1;
    repeat (4) @(posedge clk);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    @(posedge clk);
    sdaLow <= 1'b1;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sdaLow <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : stop

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte

  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, r);
  endtask : rbyte
endmodule : iox_bus_master

/* tb/iox_expander_tb_top.sv */
// Purpose: Self-checking bench for the two-wire I/O expander.
// Assumes: A behavioural bus master stands on the far side of the bus.
// Notes: A register model with its own pointer predicts reads and pins.
`timescale 1ns/1ns
module iox_expander_tb_top import iox_pkg::*; ;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] strap = 3'h0;
  logic [7:0] extA = 8'h00;
  logic [7:0] extB = 8'h00;
  logic [7:0] inA, inB, outA, outB, oeA, oeB;
  logic scl, sdaLow, sdaOut, sdaOe, intOut, intOe, sdaWire;
  logic [7:0] mreg [8];
  int ptr = 0;
  integer seed = 32'h9440;
  int nMismatch = 0;
  int totalChecks = 0;

  always #5 core_clk = ~core_clk;
  assign sdaWire = !(sdaOe === 1'b1 && sdaOut === 1'b0) && !sdaLow;
  assign inA = (oeA & outA) | (~oeA & extA);
  assign inB = (oeB & outB) | (~oeB & extB);

  iox_expander #(.W(8)) DUT (
    .core_clk(core_clk), .srst(srst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .addrStrapPins(strap), .firstPortPinsIn(inA),
    .firstPortPinsOut(outA), .firstPortPinsOe(oeA), .secondPortPinsIn(inB),
    .secondPortPinsOut(outB), .secondPortPinsOe(oeB), .intOut(intOut), .intOe(intOe)
  );
  iox_bus_master u_mst (.clk(core_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));

  // --------------------------------------------------------------
  // Model and bus tasks
  // --------------------------------------------------------------
  function automatic logic [7:0] pin(input int p);
    logic [7:0] e;
    e = p ? extB : extA;
    return (~mreg[6 + p] & mreg[2 + p]) | (mreg[6 + p] & e);
  endfunction : pin

  function automatic logic [7:0] expv(input int r);
    return (r < 2) ? pin(r) ^ mreg[4 + r] : mreg[r];
  endfunction : expv

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic addr(input logic [7:0] b, input logic e);
    logic ack;
    u_mst.start();
    u_mst.wbyte(b, ack);
    chk(8'(ack), 8'(e), "address ack");
  endtask : addr

  // A pointer-only write leaves the bus open for a repeated start.
  task automatic wr(input int r, input int n);
    logic [7:0] d;
    logic ack;
    addr({ADDR_FIXED, strap, 1'b0}, 1'b1);
    d = 8'($random(seed));
    u_mst.wbyte({d[7:3], r[2:0]}, ack);
    chk(8'(ack), 8'h01, "pointer ack");
    ptr = r;
    repeat (n) begin
      d = 8'($random(seed));
      u_mst.wbyte(d, ack);
      chk(8'(ack), 8'h01, "data ack");
      if (ptr > 1) mreg[ptr] = d;
      ptr = ptr ^ 1;
    end
    if (n > 0) u_mst.stop();
  endtask : wr

  task automatic rd(input int n);
    logic [7:0] d;
    logic [7:0] e;
    addr({ADDR_FIXED, strap, RW_READ}, 1'b1);
    for (int i = 1; i <= n; i++) begin
      e = expv(ptr);
      u_mst.rbyte(i < n, d);
      chk(d, e, "read data");
      if (i < n) ptr = ptr ^ 1;
    end
    u_mst.stop();
  endtask : rd

  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : testDone

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    logic ack;
    logic [7:0] m;
    mreg = '{8'h00, 8'h00, LATCH_RST, LATCH_RST, INV_RST, INV_RST, DIR_RST, DIR_RST};
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(oeA | oeB, 8'h00, "reset drive");
    for (int r = 2; r < 8; r += 2) begin
      wr(r, 0);
      rd(3);
    end
    $display("test register map done");
    wr(3, 3);
    wr(7, 1);
    wr(6, 3);
    extA <= 8'($random(seed));
    extB <= 8'($random(seed));
    repeat (4) @(posedge core_clk);
    chk(oeA, ~mreg[6], "drive port 0");
    chk(oeB, ~mreg[7], "drive port 1");
    chk(outA, mreg[2], "latch port 0");
    chk(outB, mreg[3], "latch port 1");
    wr(4, 2);
    wr(0, 3);
    for (int r = 0; r < 8; r += 2) begin
      wr(r, 0);
      rd(2);
    end
    rd(3);
    $display("test write and read done");
    for (int s = 0; s < 8; s++) begin
      strap <= s[2:0];
      repeat (4) @(posedge core_clk);
      addr({ADDR_FIXED, ~s[2:0], 1'b0}, 1'b0);
      u_mst.wbyte(8'($random(seed)), ack);
      chk(8'(ack), 8'h00, "foreign data");
      u_mst.stop();
      addr(8'h00, 1'b0);
      u_mst.stop();
      rd(1);
    end
    $display("test address done");
    wr(1, 0);
    rd(2);
    m = mreg[7] & (~mreg[7] + 8'h01);
    chk(8'(intOe), 8'h00, "int idle");
    extB <= extB ^ m;
    repeat (6) @(posedge core_clk);
    chk(8'(intOe), 8'(m != 0), "int raised");
    wr(0, 0);
    rd(1);
    chk(8'(intOe), 8'(m != 0), "int kept");
    wr(1, 0);
    rd(1);
    chk(8'(intOe), 8'h00, "int read clear");
    extB <= extB ^ m;
    repeat (6) @(posedge core_clk);
    chk(8'(intOe), 8'(m != 0), "int again");
    extB <= extB ^ m;
    repeat (6) @(posedge core_clk);
    chk(8'(intOe), 8'h00, "int level return");
    $display("test interrupt done");
    testDone();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    nMismatch++;
    testDone();
  end
endmodule : iox_expander_tb_top
